//--- crma_pkg.sv
package crma_pkg;

  // ---------------------------------------------------------------
  // Tokens and framing
  // ---------------------------------------------------------------
  localparam logic [7:0] CT_END       = 8'h01;
  localparam logic [7:0] CT_ACK       = 8'h03;
  localparam logic [7:0] CT_NACK      = 8'h04;
  localparam logic [7:0] CT_PER_WR    = 8'h24;
  localparam logic [7:0] CT_PER_RD    = 8'h25;
  localparam logic [7:0] CT_CFG_WR    = 8'hc0;
  localparam logic [7:0] CT_CFG_RD    = 8'hc1;
  localparam int         PS_SHIFT     = 8;
  localparam logic [7:0] PS_RES_TYPE  = 8'h0c;
  localparam logic [15:0] TILE_DEST_LO = 16'hc20c;
  localparam logic [15:0] NODE_DEST_LO = 16'hc30c;
  localparam logic [7:0]  PER_DEST_LO  = 8'h02;
  localparam int          NUM_BANKS    = 10;
  localparam logic [2:0]  CNT_REPLY    = 3'h2;
  localparam logic [2:0]  CNT_REG16    = 3'h1;
  localparam logic [2:0]  CNT_DATA32   = 3'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } crma_tok_t;

  typedef struct packed {
    logic [23:0] dest;
    crma_tok_t   tok;
  } crma_otok_t;

  typedef enum logic [1:0] {CLS_NONE, CLS_TILE, CLS_NODE, CLS_PER} crma_cls_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    crma_cls_t   cls;
    logic [7:0]  periph;
    logic [15:0] regnum;
    logic [31:0] wdata;
  } crma_acc_t;

endpackage : crma_pkg

//--- crma_buf.sv
`timescale 1ns/1ps
// Two-entry skid buffer for outgoing tokens
module crma_buf #(
  parameter int W = 34
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd;
    logic              wr;
    logic [1:0]        cnt;
  } crma_buf_st_t;

  crma_buf_st_t st;
  crma_buf_st_t next_st;
  logic         push;
  logic         pop;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    push    = in_valid && (st.cnt != 2'd2);
    pop     = out_ready && (st.cnt != 2'd0);
    if (push)
    begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = ~st.wr;
    end
    if (pop)
      next_st.rd = ~st.rd;
    next_st.cnt = st.cnt + 2'(push) - 2'(pop);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  // Full and empty read straight from the count
  assign in_ready  = (st.cnt != 2'd2);
  assign out_valid = (st.cnt != 2'd0);
  assign out_data  = st.mem[st.rd];
endmodule : crma_buf

//--- crma_engine.sv
`timescale 1ns/1ps
module crma_engine
  import crma_pkg::*;
#(
  parameter int MAX_PBYTES = 4
) (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic [15:0]         own_id,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  input  wire crma_pkg::crma_tok_t rx_tok,
  input  wire logic [31:0]         rx_dest,
  output logic                     acc_req,
  output crma_pkg::crma_acc_t      acc,
  input  wire logic                acc_done,
  input  wire logic                acc_ok,
  input  wire logic [31:0]         acc_rdata,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output crma_pkg::crma_otok_t     tx_out
);
  import crma_pkg::*;

  typedef enum logic [2:0] {S_HDR, S_FIELD, S_ACCESS, S_WAIT, S_REPLY, S_DRAIN} crma_state_t;

  typedef struct packed {
    crma_state_t state;
    logic        rx_ready;
    logic [7:0]  op;
    crma_acc_t   acc;
    logic [23:0] reply;
    logic [2:0]  fld;
    logic [2:0]  cnt;
    logic [7:0]  size;
    logic        bad;
    logic [31:0] rdata;
    logic        ok;
    logic [3:0]  rstep;
    logic [7:0]  rlen;
    logic        t_valid;
    crma_otok_t  t_tok;
  } crma_st_t;

  crma_st_t   st;
  crma_st_t   next_st;
  logic       b_in_ready;
  logic       b_valid;
  crma_otok_t b_data;
  logic       rx_fire;
  crma_cls_t  cls;

  // ---------------------------------------------------------------
  // Destination decode
  // ---------------------------------------------------------------
  always_comb
  begin
    cls = CLS_NONE;
    if (rx_dest[31:16] == own_id && rx_dest[15:0] == TILE_DEST_LO)
      cls = CLS_TILE;
    else if (rx_dest[31:16] == own_id && rx_dest[15:0] == NODE_DEST_LO)
      cls = CLS_NODE;
    else if (rx_dest[31:16] == own_id && rx_dest[7:0] == PER_DEST_LO)
      cls = CLS_PER;
  end

  // ---------------------------------------------------------------
  // Message parse, access and reply
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st         = st;
    rx_fire         = rx_valid && st.rx_ready;
    next_st.acc.req = 1'b0;
    if (b_in_ready)
      next_st.t_valid = 1'b0;
    unique case (st.state)
      S_HDR:
      begin
        if (rx_fire)
        begin
          next_st.op        = rx_tok.data;
          next_st.acc.cls   = cls;
          next_st.acc.periph = rx_dest[15:8];
          next_st.acc.wdata = '0;
          next_st.fld       = 3'd0;
          next_st.cnt       = CNT_REPLY;
          next_st.bad       = 1'b0;
          next_st.size      = '0;
          if (rx_tok.ctrl && rx_tok.data == CT_END)
            next_st.state = S_HDR;                        // Stray closer, skip
          else if (!rx_tok.ctrl)
            next_st.bad = 1'b1;
          else if (cls == CLS_PER)
            next_st.bad = !(rx_tok.data == CT_PER_WR || rx_tok.data == CT_PER_RD);
          else
            next_st.bad = (cls == CLS_NONE)
                       || !(rx_tok.data == CT_CFG_WR || rx_tok.data == CT_CFG_RD);
          if (!(rx_tok.ctrl && rx_tok.data == CT_END))
            next_st.state = S_FIELD;
        end
      end
      // Fields: 0 reply, 1 register, 2 size, 3 data, 4 closer
      S_FIELD:
      begin
        if (rx_fire)
        begin
          if (rx_tok.ctrl)
          begin
            // Closer must land exactly after the last field
            if (rx_tok.data != CT_END || st.fld != 3'd4)
              next_st.bad = 1'b1;
            next_st.rx_ready = 1'b0;
            next_st.state    = S_ACCESS;
          end
          else
          begin
            unique case (st.fld)
              3'd0: next_st.reply = {st.reply[15:0], rx_tok.data};
              3'd1: next_st.acc.regnum = {st.acc.regnum[7:0], rx_tok.data};
              3'd2: next_st.size = rx_tok.data;
              3'd3: next_st.acc.wdata = {st.acc.wdata[23:0], rx_tok.data};
              default: next_st.bad = 1'b1;                // Extra data token
            endcase
            if (st.fld == 3'd1 && st.cnt == 3'd0 && st.acc.cls == CLS_PER)
              next_st.acc.regnum = {8'h00, rx_tok.data};
            if (st.cnt != 3'd0)
              next_st.cnt = st.cnt - 3'd1;
            else
            begin
              // Advance to the next field of this message type
              unique case (st.fld)
                3'd0:
                begin
                  next_st.fld = 3'd1;
                  next_st.cnt = (st.acc.cls == CLS_PER) ? 3'd0 : CNT_REG16;
                end
                3'd1:
                begin
                  if (st.acc.cls == CLS_PER)
                    next_st.fld = 3'd2;
                  else if (st.op == CT_CFG_WR)
                  begin
                    next_st.fld = 3'd3;
                    next_st.cnt = CNT_DATA32;
                  end
                  else
                    next_st.fld = 3'd4;
                end
                3'd2:
                begin
                  if (rx_tok.data == 8'h00 || rx_tok.data > 8'(MAX_PBYTES))
                    next_st.bad = 1'b1;
                  if (st.op == CT_PER_WR && rx_tok.data != 8'h00)
                  begin
                    next_st.fld = 3'd3;
                    next_st.cnt = 3'(rx_tok.data - 8'h01);
                  end
                  else
                    next_st.fld = 3'd4;
                end
                default: next_st.fld = 3'd4;
              endcase
            end
          end
        end
      end
      S_ACCESS:
      begin
        next_st.acc.wr = (st.op == CT_CFG_WR) || (st.op == CT_PER_WR);
        next_st.ok     = 1'b0;
        if (st.bad)
          next_st.state = S_REPLY;
        else
        begin
          next_st.acc.req = 1'b1;
          next_st.state   = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (acc_done)
        begin
          next_st.ok    = acc_ok;
          next_st.rdata = acc_rdata;
          next_st.state = S_REPLY;
        end
      end
      S_REPLY:
      begin
        // Reply: ack/nack, optional data bytes msb first, closer
        next_st.rlen = (st.ok && !st.acc.wr) ? ((st.acc.cls == CLS_PER) ? st.size : 8'd4) : 8'd0;
        if (b_in_ready)
        begin
          next_st.t_valid    = 1'b1;
          next_st.t_tok.dest = st.reply;
          if (st.rstep == 4'd0)
            next_st.t_tok.tok = '{ctrl: 1'b1, data: st.ok ? CT_ACK : CT_NACK};
          else if (8'(st.rstep) <= next_st.rlen)
            next_st.t_tok.tok = '{ctrl: 1'b0,
                                  data: 8'(st.rdata >> (8 * (32'(next_st.rlen) - 32'(st.rstep))))};
          else
            next_st.t_tok.tok = '{ctrl: 1'b1, data: CT_END};
          if (8'(st.rstep) > next_st.rlen)
          begin
            next_st.rstep = 4'd0;
            next_st.state = S_DRAIN;
          end
          else
            next_st.rstep = st.rstep + 4'd1;
        end
      end
      S_DRAIN:
      begin
        next_st.rx_ready = 1'b1;
        next_st.state    = S_HDR;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st          <= '0;
      st.state    <= S_HDR;
      st.rx_ready <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Registered output stage, read by the buffer's pop below
  logic       tx_valid_q;
  crma_otok_t tx_q;

  // ---------------------------------------------------------------
  // Output buffer; a stalled receiver holds the reply, not drops it
  // ---------------------------------------------------------------
  crma_buf #(
    .W ($bits(crma_otok_t))
  ) u_buf (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (st.t_valid),
    .in_ready  (b_in_ready),
    .in_data   (st.t_tok),
    .out_valid (b_valid),
    .out_ready (!tx_valid_q),
    .out_data  (b_data)
  );

  // Pop only into an empty stage, so a stalled word is never shown twice
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_valid_q <= 1'b0;
      tx_q       <= '0;
    end
    else if (!tx_valid_q || tx_ready)
    begin
      tx_valid_q <= b_valid && !tx_valid_q;
      tx_q       <= b_data;
    end
  end

  assign rx_ready = st.rx_ready;
  assign acc_req  = st.acc.req;
  assign acc      = st.acc;
  assign tx_valid = tx_valid_q;
  assign tx_out   = tx_q;
endmodule : crma_engine

//--- crma_engine_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Engine port checker
// ---------------------------------------------
module crma_engine_assertions
  import crma_pkg::*;
#(
  parameter int MAX_PBYTES = 4
) (
  input wire logic                ref_clk,
  input wire logic                reset,
  input wire logic [15:0]         own_id,
  input wire logic                rx_valid,
  input wire logic                rx_ready,
  input wire crma_pkg::crma_tok_t rx_tok,
  input wire logic [31:0]         rx_dest,
  input wire logic                acc_req,
  input wire crma_pkg::crma_acc_t acc,
  input wire logic                acc_done,
  input wire logic                acc_ok,
  input wire logic [31:0]         acc_rdata,
  input wire logic                tx_valid,
  input wire logic                tx_ready,
  input wire crma_pkg::crma_otok_t tx_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Reset must leave the engine idle and open
  a_rst_quiet: assert property (disable iff (1'b0) reset |=> rx_ready && !tx_valid && !acc_req)
    else $error("engine not idle after reset");
  a_req_pulse: assert property (acc_req |=> !acc_req)
    else $error("access request longer than one cycle");
  a_req_class: assert property (acc_req |-> acc.cls != CLS_NONE)
    else $error("access request without a register class");
  a_busy_refuse: assert property (acc_req |-> !rx_ready)
    else $error("tokens accepted while access pending");
  // A stalled reply token may not move under the receiver
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_out))
    else $error("reply token changed while stalled");
  a_ack_reply: assert property (acc_done && acc_ok |-> ##[1:30] tx_valid && tx_out.tok == {1'b1, CT_ACK})
    else $error("no success token after good access");
  a_nack_reply: assert property (acc_done && !acc_ok |-> ##[1:30] tx_valid && tx_out.tok == {1'b1, CT_NACK})
    else $error("no failure token after bad access");
  a_nack_close: assert property (tx_valid && tx_ready && tx_out.tok == {1'b1, CT_NACK}
    |=> ##[0:40] tx_valid && tx_out.tok == {1'b1, CT_END})
    else $error("failure reply not closed");

  c_write: cover property (acc_req && acc.wr);
  c_per_read: cover property (acc_req && !acc.wr && acc.cls == CLS_PER);
  c_nack: cover property (tx_valid && tx_out.tok == {1'b1, CT_NACK});
endmodule : crma_engine_assertions

//--- crma_reg_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Register side responder
// ---------------------------------------------
module crma_reg_model
  import crma_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                reset,
  input wire logic                acc_req,
  input wire crma_pkg::crma_acc_t acc,
  input wire logic                fail,
  input wire logic [2:0]          lag,
  output logic                    acc_done,
  output logic                    acc_ok,
  output logic [31:0]             acc_rdata
);
  logic        busy;
  logic [2:0]  wait_cnt;
  logic [31:0] val;
  logic [31:0] last_wr;

  // Whole word answer after a variable lag; outside done the lines churn.
  // Reads give the number twice xor the last written word, so write data is seen again.
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      busy      <= 1'b0;
      acc_done  <= 1'b0;
      acc_ok    <= 1'b0;
      acc_rdata <= 32'h0;
      last_wr   <= 32'h0;
    end
    else if (busy && wait_cnt == 3'h0)
    begin
      busy      <= 1'b0;
      acc_done  <= 1'b1;
      acc_ok    <= !fail;
      acc_rdata <= val;
    end
    else
    begin
      acc_done  <= 1'b0;
      acc_ok    <= ~acc_ok;
      acc_rdata <= ~acc_rdata;
      if (acc_req)
      begin
        busy     <= 1'b1;
        wait_cnt <= lag;
        val      <= {acc.regnum, acc.regnum} ^ last_wr;
        if (acc.wr)
          last_wr <= acc.wdata;
      end
      else if (busy)
        wait_cnt <= wait_cnt - 3'h1;
    end
  end
endmodule : crma_reg_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import crma_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] own_id = 16'h0012;
  logic        rx_valid = 1'b0;
  logic        rx_ready, acc_req, acc_done, acc_ok, tx_valid;
  crma_tok_t   rx_tok = '0;
  logic [31:0] rx_dest = '0;
  crma_acc_t   acc;
  logic [31:0] acc_rdata;
  logic        tx_ready = 1'b0;
  crma_otok_t  tx_out;
  logic        fail = 1'b0;
  logic [2:0]  lag = 3'h0;
  crma_otok_t  exp_q[$];
  int          mismatches = 0;
  int          n_compared = 0;
  logic [23:0] rid;

  always #12.5 ref_clk = ~ref_clk;

  crma_engine #(.MAX_PBYTES(4)) i_crma_engine (.ref_clk(ref_clk), .reset(reset), .own_id(own_id),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_tok(rx_tok), .rx_dest(rx_dest), .acc_req(acc_req),
    .acc(acc), .acc_done(acc_done), .acc_ok(acc_ok), .acc_rdata(acc_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_out(tx_out));
  crma_reg_model i_crma_reg_model (.ref_clk(ref_clk), .reset(reset), .acc_req(acc_req), .acc(acc),
    .fail(fail), .lag(lag), .acc_done(acc_done), .acc_ok(acc_ok), .acc_rdata(acc_rdata));

  // Receiver stalls and access lag vary every cycle
  always @(posedge ref_clk)
  begin
    tx_ready <= ($urandom % 4) != 0;
    lag      <= 3'($urandom % 6);
  end

  task check(input crma_otok_t seen, input crma_otok_t want);
    n_compared++;
    if (seen !== want)
    begin
      mismatches++;
      $display("Error at %0t: reply token %h, expected %h", $time, seen, want);
    end
  endtask : check

  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // Valid stays up between tokens so it is never driven twice in one step
  task send(input logic c, input logic [7:0] b);
    int i;
    rx_valid <= 1'b1;
    rx_tok   <= {c, b};
    @(posedge ref_clk);
    for (i = 0; i < 200 && !rx_ready; i++)
      @(posedge ref_clk);
    if (i == 200)
    begin
      mismatches++;
      complete_run();
    end
  endtask : send

  // One message: header, reply id and body msb first, closer
  task msg(input logic [31:0] d, input logic [7:0] op, input int n, input logic [63:0] body,
           input logic ok, input int nrd, input logic [31:0] rd);
    logic [87:0] full;
    int i;
    rid  = 24'($urandom);
    full = (88'(rid) << (8 * (n - 3))) | 88'(body);
    exp_q.push_back({rid, 1'b1, ok ? CT_ACK : CT_NACK});
    for (i = 0; i < nrd && ok; i++)
      exp_q.push_back({rid, 1'b0, rd[8 * (nrd - 1 - i) +: 8]});
    exp_q.push_back({rid, 1'b1, CT_END});
    rx_dest <= d;
    send(1'b1, op);
    for (i = 0; i < n; i++)
      send(1'b0, full[8 * (n - 1 - i) +: 8]);
    send(1'b1, CT_END);
    rx_valid <= 1'b0;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++)
      @(posedge ref_clk);
    if (exp_q.size() > 0)
    begin
      mismatches++;
      complete_run();
    end
    $display("test with header %h done", op);
  endtask : msg

  // Reply watcher
  always @(posedge ref_clk)
    if (!reset && tx_valid && tx_ready)
      if (exp_q.size() == 0)
        check(tx_out, '0);
      else
        check(tx_out, exp_q.pop_front());

  initial
  begin
    logic [15:0] r;
    logic [31:0] w;
    logic [31:0] tile;
    logic [31:0] per;
    void'($urandom(88));
    tile = {own_id, TILE_DEST_LO};
    per  = {own_id, 8'h03, PER_DEST_LO};
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // Register number shaped like a status resource id; reads return number twice xor last write
    r = 16'(($urandom % 256) << PS_SHIFT) | 16'(PS_RES_TYPE);
    w = $urandom;
    msg(tile, CT_CFG_WR, 9, {r, w}, 1'b1, 0, '0);
    msg({own_id, NODE_DEST_LO}, CT_CFG_RD, 5, 64'(r), 1'b1, 4, {r, r} ^ w);
    msg(per, CT_PER_WR, 7, {r[7:0], 8'h02, r}, 1'b1, 0, '0);
    msg(per, CT_PER_RD, 5, {r[7:0], 8'h04}, 1'b1, 4, {8'h00, r[7:0], r[15:8], 8'h00});
    msg(per, CT_PER_RD, 5, {r[7:0], 8'h02}, 1'b1, 2, {16'h0, r[15:8], 8'h00});
    fail <= 1'b1;
    msg(tile, CT_CFG_WR, 9, {r, 32'($urandom)}, 1'b0, 0, '0);
    fail <= 1'b0;
    msg({~own_id, TILE_DEST_LO}, CT_CFG_RD, 5, 64'(r), 1'b0, 0, '0);
    msg(per, CT_PER_RD, 5, {r[7:0], 8'h00}, 1'b0, 0, '0);
    msg(tile, CT_CFG_RD, 4, 64'(r[7:0]), 1'b0, 0, '0);
    msg(tile, CT_PER_RD, 5, {r[7:0], 8'h01}, 1'b0, 0, '0);
    complete_run();
  end
endmodule : testbench

bind crma_engine crma_engine_assertions #(.MAX_PBYTES(MAX_PBYTES)) i_crma_engine_assertions (
  .ref_clk(ref_clk), .reset(reset), .own_id(own_id), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_tok(rx_tok), .rx_dest(rx_dest), .acc_req(acc_req), .acc(acc), .acc_done(acc_done),
  .acc_ok(acc_ok), .acc_rdata(acc_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_out(tx_out));
